// ---- src/dsf_defs.vh ----
// Constants for the drive status output flag block
`ifndef DSF_DEFS_VH
`define DSF_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DSF_OFS_CTRL 12'h000
`define DSF_OFS_THRESH 12'h004
`define DSF_OFS_TERM_SEL 12'h008
`define DSF_OFS_RELAY_SEL 12'h00c
`define DSF_OFS_STATUS 12'h010

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DSF_CTRL_SRC_BIT 0
`define DSF_CTRL_SW_FWD_BIT 1
`define DSF_CTRL_SW_REV_BIT 2
`define DSF_CTRL_LC_MODE_LSB 3
`define DSF_CTRL_LC_MODE_MSB 4
`define DSF_THR_TEMP_LSB 0
`define DSF_THR_TEMP_MSB 7
`define DSF_THR_LEVEL_LSB 16
`define DSF_THR_LEVEL_MSB 31
`define DSF_STAT_TERM_LSB 8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DSF_RST_CTRL 5'h00
`define DSF_RST_TEMP 8'h78
`define DSF_RST_LEVEL 16'h0000
`define DSF_RST_SEL 6'h00

// ----------------------------------------------------------------
// Limits and encodings
// ----------------------------------------------------------------
`define DSF_TEMP_MAX 8'hc8
`define DSF_LC_MODE_ALWAYS 2'h0
`define DSF_LC_MODE_CONST 2'h1

// Terminal function codes (decimal values in hex)
`define DSF_FN_OVERHEAT 6'h2a
`define DSF_FN_LOW_CUR 6'h2b
`define DSF_FN_START 6'h2c
`define DSF_FN_READY 6'h32
`define DSF_FN_FWD 6'h33
`define DSF_FN_REV 6'h34
`define DSF_FN_MAJOR 6'h35

// Hardware trip codes that raise the major failure flag
`define DSF_TRIP_CT 8'h0a
`define DSF_TRIP_CPU 8'h0b
`define DSF_TRIP_GND 8'h0e
`define DSF_TRIP_FAN 8'h14
`define DSF_TRIP_GA 8'h17
`define DSF_TRIP_MAIN 8'h19

// Flag vector positions
`define DSF_FLAG_START 0
`define DSF_FLAG_OVERHEAT 1
`define DSF_FLAG_LOW_CUR 2
`define DSF_FLAG_READY 3
`define DSF_FLAG_FWD 4
`define DSF_FLAG_REV 5
`define DSF_FLAG_MAJOR 6
`define DSF_NUM_FLAGS 7

`endif

// ---- src/dsf_term_mux.v ----
// One output terminal: function code selects a flag, registered
`timescale 1ns/1ps

module dsf_term_mux (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Selection and flags
	input wire [5:0] func_sel,
	input wire [6:0] flags,
	// Terminal level
	output reg term_out_r
);

`include "dsf_defs.vh"

reg term_nxt;

// ----------------------------------------------------------------
// Code decode
// ----------------------------------------------------------------
always @* begin
	case (func_sel)
		`DSF_FN_START: term_nxt = flags[`DSF_FLAG_START];
		`DSF_FN_OVERHEAT: term_nxt = flags[`DSF_FLAG_OVERHEAT];
		`DSF_FN_LOW_CUR: term_nxt = flags[`DSF_FLAG_LOW_CUR];
		`DSF_FN_READY: term_nxt = flags[`DSF_FLAG_READY];
		`DSF_FN_FWD: term_nxt = flags[`DSF_FLAG_FWD];
		`DSF_FN_REV: term_nxt = flags[`DSF_FLAG_REV];
		`DSF_FN_MAJOR: term_nxt = flags[`DSF_FLAG_MAJOR];
		default: term_nxt = 1'b0;
	endcase
end

always @(posedge clk) begin
	if (!rst_n) begin
		term_out_r <= 1'b0;
	end else begin
		term_out_r <= term_nxt;
	end
end

endmodule // dsf_term_mux

// ---- src/dsf_status_flags.v ----
// Drive status flags with programmable output terminals over APB
//
// Contract
// RULE1 - start contact flag while command received
// RULE2 - start contact flag ignores command source
// RULE3 - both directions commanded stops the motor
// RULE4 - overheat warning above threshold 0 to 200
// RULE5 - low current flag at or below level
// RULE6 - mode 00 always, 01 constant speed
// RULE7 - level limited to twice rated current
// RULE8 - ready flag when commands can be accepted
// RULE9 - commands arriving while not ready ignored
// RULE10 - not ready without main power
// RULE11 - forward flag while driving forward
// RULE12 - forward flag off reversing or stopping
// RULE13 - reverse flag while driving reverse
// RULE14 - reverse flag off forward or stopping
// RULE15 - major failure flag on qualifying trip
// RULE16 - only codes 10,11,14,20,23,25 qualify
// RULE17 - only hardware detected trips qualify
// RULE18 - five terminals and relay select flags
// RULE19 - registered inputs, terminals one cycle later
`timescale 1ns/1ps

module dsf_status_flags #(
	parameter NUM_TERM = 5,
	parameter CUR_W = 16
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata_r,
	output reg pready_r,
	output reg pslverr_r,
	// Run commands from terminals
	input wire forward_run_cmd,
	input wire reverse_run_cmd,
	// Drive control core state
	input wire main_power_ok,
	input wire motor_stopping,
	input wire const_speed,
	input wire [7:0] heatsink_temp,
	input wire [CUR_W-1:0] output_current,
	input wire [CUR_W-1:0] rated_current,
	input wire trip_active,
	input wire trip_hw,
	input wire [7:0] trip_code,
	// Motor drive command
	output reg motor_fwd_r,
	output reg motor_rev_r,
	// Output terminals and alarm relay
	output wire [NUM_TERM-1:0] term_out,
	output wire relay_out
);

`include "dsf_defs.vh"

// ----------------------------------------------------------------
// Functions
// ----------------------------------------------------------------
function is_major_code;
	input [7:0] code;
	begin
		case (code)
			`DSF_TRIP_CT, `DSF_TRIP_CPU, `DSF_TRIP_GND,
			`DSF_TRIP_FAN, `DSF_TRIP_GA, `DSF_TRIP_MAIN: is_major_code = 1'b1;
			default: is_major_code = 1'b0;
		endcase
	end
endfunction

// ----------------------------------------------------------------
// Declarations
// ----------------------------------------------------------------
reg src_reg_r;
reg sw_fwd_r;
reg sw_rev_r;
reg [1:0] lc_mode_r;
reg [7:0] temp_thr_r;
reg [CUR_W-1:0] lc_level_r;
reg [6*NUM_TERM-1:0] term_sel_r;
reg [5:0] relay_sel_r;

reg fw_in_r;
reg rv_in_r;
reg power_in_r;
reg stopping_in_r;
reg const_in_r;
reg [7:0] temp_in_r;
reg [CUR_W-1:0] cur_in_r;
reg [CUR_W-1:0] rated_in_r;
reg trip_in_r;
reg trip_hw_in_r;
reg [7:0] trip_code_in_r;

reg fwd_prev_r;
reg rev_prev_r;
reg fwd_armed_r;
reg rev_armed_r;
reg motor_fwd_nxt;
reg motor_rev_nxt;
reg fwd_armed_nxt;
reg rev_armed_nxt;

wire cmd_fwd;
wire cmd_rev;
wire [7:0] temp_thr_eff;
wire [CUR_W:0] level_max;
wire [CUR_W:0] level_eff;
wire lc_enable;
wire [6:0] flags;

wire apb_setup;
wire apb_wr;
reg [31:0] rd_nxt;
reg err_nxt;

// ----------------------------------------------------------------
// Input registers
// ----------------------------------------------------------------
always @(posedge clk) begin
	if (!rst_n) begin
		fw_in_r <= 1'b0;
		rv_in_r <= 1'b0;
		power_in_r <= 1'b0;
		stopping_in_r <= 1'b0;
		const_in_r <= 1'b0;
		temp_in_r <= 8'h00;
		cur_in_r <= {CUR_W{1'b0}};
		rated_in_r <= {CUR_W{1'b0}};
		trip_in_r <= 1'b0;
		trip_hw_in_r <= 1'b0;
		trip_code_in_r <= 8'h00;
	end else begin
		fw_in_r <= forward_run_cmd; // see RULE19
		rv_in_r <= reverse_run_cmd;
		power_in_r <= main_power_ok;
		stopping_in_r <= motor_stopping;
		const_in_r <= const_speed;
		temp_in_r <= heatsink_temp;
		cur_in_r <= output_current;
		rated_in_r <= rated_current;
		trip_in_r <= trip_active;
		trip_hw_in_r <= trip_hw;
		trip_code_in_r <= trip_code;
	end
end

// ----------------------------------------------------------------
// Run command selection and acceptance
// ----------------------------------------------------------------
assign cmd_fwd = src_reg_r ? sw_fwd_r : fw_in_r;
assign cmd_rev = src_reg_r ? sw_rev_r : rv_in_r;

// Ready without main power or during a trip is never given
assign flags[`DSF_FLAG_READY] = power_in_r & ~trip_in_r; // see RULE8 see RULE10
// Command received on whichever source is selected
assign flags[`DSF_FLAG_START] = cmd_fwd | cmd_rev; // see RULE1 see RULE2

// A command edge is armed only while ready; one seen while not ready
// stays ignored until the command is released and given again
always @* begin
	fwd_armed_nxt = fwd_armed_r;
	rev_armed_nxt = rev_armed_r;
	if (!cmd_fwd) begin
		fwd_armed_nxt = 1'b0;
	end else if (cmd_fwd && !fwd_prev_r && flags[`DSF_FLAG_READY]) begin
		fwd_armed_nxt = 1'b1; // see RULE9
	end
	if (!cmd_rev) begin
		rev_armed_nxt = 1'b0;
	end else if (cmd_rev && !rev_prev_r && flags[`DSF_FLAG_READY]) begin
		rev_armed_nxt = 1'b1; // see RULE9
	end
	if (!flags[`DSF_FLAG_READY]) begin
		fwd_armed_nxt = 1'b0;
		rev_armed_nxt = 1'b0;
	end
	motor_fwd_nxt = fwd_armed_nxt & ~cmd_rev; // see RULE3
	motor_rev_nxt = rev_armed_nxt & ~cmd_fwd; // see RULE3
end

always @(posedge clk) begin
	if (!rst_n) begin
		fwd_prev_r <= 1'b0;
		rev_prev_r <= 1'b0;
		fwd_armed_r <= 1'b0;
		rev_armed_r <= 1'b0;
		motor_fwd_r <= 1'b0;
		motor_rev_r <= 1'b0;
	end else begin
		fwd_prev_r <= cmd_fwd;
		rev_prev_r <= cmd_rev;
		fwd_armed_r <= fwd_armed_nxt;
		rev_armed_r <= rev_armed_nxt;
		motor_fwd_r <= motor_fwd_nxt;
		motor_rev_r <= motor_rev_nxt;
	end
end

// ----------------------------------------------------------------
// Rotation flags
// ----------------------------------------------------------------
assign flags[`DSF_FLAG_FWD] = motor_fwd_r & ~stopping_in_r; // see RULE11 see RULE12
assign flags[`DSF_FLAG_REV] = motor_rev_r & ~stopping_in_r; // see RULE13 see RULE14

// ----------------------------------------------------------------
// Overheat warning
// ----------------------------------------------------------------
assign temp_thr_eff = (temp_thr_r > `DSF_TEMP_MAX) ? `DSF_TEMP_MAX : temp_thr_r;
assign flags[`DSF_FLAG_OVERHEAT] = temp_in_r > temp_thr_eff; // see RULE4

// ----------------------------------------------------------------
// Low current indication
// ----------------------------------------------------------------
assign level_max = {rated_in_r, 1'b0};
assign level_eff = ({1'b0, lc_level_r} > level_max) ? level_max : {1'b0, lc_level_r}; // see RULE7
assign lc_enable = (motor_fwd_r | motor_rev_r) &
	((lc_mode_r == `DSF_LC_MODE_ALWAYS) ||
	((lc_mode_r == `DSF_LC_MODE_CONST) && const_in_r)); // see RULE6
assign flags[`DSF_FLAG_LOW_CUR] = lc_enable & ({1'b0, cur_in_r} <= level_eff); // see RULE5

// ----------------------------------------------------------------
// Major failure
// ----------------------------------------------------------------
assign flags[`DSF_FLAG_MAJOR] = trip_in_r & trip_hw_in_r & // see RULE15 see RULE17
	is_major_code(trip_code_in_r); // see RULE16

// ----------------------------------------------------------------
// Output terminals and relay
// ----------------------------------------------------------------
genvar gi;
generate
	for (gi = 0; gi < NUM_TERM; gi = gi + 1) begin : g_term
		dsf_term_mux u_term (
			.clk(clk),
			.rst_n(rst_n),
			.func_sel(term_sel_r[6*gi +: 6]),
			.flags(flags),
			.term_out_r(term_out[gi])
		); // see RULE18 see RULE19
	end
endgenerate

dsf_term_mux u_relay (
	.clk(clk),
	.rst_n(rst_n),
	.func_sel(relay_sel_r),
	.flags(flags),
	.term_out_r(relay_out)
); // see RULE18

// ----------------------------------------------------------------
// APB slave, one wait state
// ----------------------------------------------------------------
assign apb_setup = psel & penable & ~pready_r;
assign apb_wr = apb_setup & pwrite;

always @* begin
	rd_nxt = 32'h00000000;
	err_nxt = 1'b0;
	case (paddr)
		`DSF_OFS_CTRL: begin
			rd_nxt[`DSF_CTRL_SRC_BIT] = src_reg_r;
			rd_nxt[`DSF_CTRL_SW_FWD_BIT] = sw_fwd_r;
			rd_nxt[`DSF_CTRL_SW_REV_BIT] = sw_rev_r;
			rd_nxt[`DSF_CTRL_LC_MODE_MSB:`DSF_CTRL_LC_MODE_LSB] = lc_mode_r;
		end
		`DSF_OFS_THRESH: begin
			rd_nxt[`DSF_THR_TEMP_MSB:`DSF_THR_TEMP_LSB] = temp_thr_r;
			rd_nxt[`DSF_THR_LEVEL_LSB +: CUR_W] = lc_level_r;
		end
		`DSF_OFS_TERM_SEL: begin
			rd_nxt[6*NUM_TERM-1:0] = term_sel_r;
		end
		`DSF_OFS_RELAY_SEL: begin
			rd_nxt[5:0] = relay_sel_r;
		end
		`DSF_OFS_STATUS: begin
			rd_nxt[`DSF_NUM_FLAGS-1:0] = flags;
			rd_nxt[`DSF_STAT_TERM_LSB +: NUM_TERM] = term_out;
			rd_nxt[`DSF_STAT_TERM_LSB + NUM_TERM] = relay_out;
			rd_nxt[`DSF_STAT_TERM_LSB + NUM_TERM + 1] = motor_fwd_r;
			rd_nxt[`DSF_STAT_TERM_LSB + NUM_TERM + 2] = motor_rev_r;
		end
		default: begin
			err_nxt = 1'b1;
		end
	endcase
end

always @(posedge clk) begin
	if (!rst_n) begin
		pready_r <= 1'b0;
		pslverr_r <= 1'b0;
		prdata_r <= 32'h00000000;
	end else begin
		pready_r <= apb_setup;
		pslverr_r <= apb_setup & err_nxt;
		prdata_r <= (apb_setup && !pwrite) ? rd_nxt : 32'h00000000;
	end
end

// Writes take effect at the edge where pready is sampled high
always @(posedge clk) begin
	if (!rst_n) begin
		src_reg_r <= 1'b0;
		sw_fwd_r <= 1'b0;
		sw_rev_r <= 1'b0;
		lc_mode_r <= `DSF_LC_MODE_ALWAYS;
		temp_thr_r <= `DSF_RST_TEMP;
		lc_level_r <= `DSF_RST_LEVEL;
		term_sel_r <= {NUM_TERM{`DSF_RST_SEL}};
		relay_sel_r <= `DSF_RST_SEL;
	end else if (psel && penable && pready_r && pwrite) begin
		case (paddr)
			`DSF_OFS_CTRL: begin
				src_reg_r <= pwdata[`DSF_CTRL_SRC_BIT];
				sw_fwd_r <= pwdata[`DSF_CTRL_SW_FWD_BIT];
				sw_rev_r <= pwdata[`DSF_CTRL_SW_REV_BIT];
				lc_mode_r <= pwdata[`DSF_CTRL_LC_MODE_MSB:`DSF_CTRL_LC_MODE_LSB];
			end
			`DSF_OFS_THRESH: begin
				temp_thr_r <= pwdata[`DSF_THR_TEMP_MSB:`DSF_THR_TEMP_LSB];
				lc_level_r <= pwdata[`DSF_THR_LEVEL_LSB +: CUR_W];
			end
			`DSF_OFS_TERM_SEL: begin
				term_sel_r <= pwdata[6*NUM_TERM-1:0];
			end
			`DSF_OFS_RELAY_SEL: begin
				relay_sel_r <= pwdata[5:0];
			end
			default: begin
				relay_sel_r <= relay_sel_r;
			end
		endcase
	end
end

endmodule // dsf_status_flags

// ---- verif/dsf_status_flags_checker.sv ----
// Port-level assertions for the drive status flag block
`timescale 1ns/1ps

module dsf_status_flags_checker #(
	parameter NUM_TERM = 5
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// APB
	input wire psel,
	input wire penable,
	input wire [31:0] prdata_r,
	input wire pready_r,
	input wire pslverr_r,
	// Commands and state
	input wire forward_run_cmd,
	input wire reverse_run_cmd,
	input wire main_power_ok,
	input wire trip_active,
	// Outputs
	input wire motor_fwd_r,
	input wire motor_rev_r,
	input wire [NUM_TERM-1:0] term_out,
	input wire relay_out
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence access_wait;
		psel && penable && !pready_r;
	endsequence
	sequence both_held;
		(forward_run_cmd && reverse_run_cmd) [*3];
	endsequence

	access_answer_a: assert property (access_wait |=> pready_r)
		else $error("access phase not answered after one wait state");
	ready_pulse_a: assert property (pready_r |=> !pready_r)
		else $error("ready held longer than one cycle");
	idle_rdata_a: assert property (!pready_r |-> prdata_r == 32'h0)
		else $error("read data not zero outside answer");
	err_with_ready_a: assert property (pslverr_r |-> pready_r)
		else $error("error flag without ready");
	reset_clear_a: assert property ($rose(rst_n) |->
		term_out == {NUM_TERM{1'b0}} && !relay_out && !motor_fwd_r && !motor_rev_r)
		else $error("outputs not cleared by reset");
	motor_excl_a: assert property (!(motor_fwd_r && motor_rev_r))
		else $error("both motor directions driven");
	both_stop_a: assert property (both_held |-> !motor_fwd_r && !motor_rev_r)
		else $error("motor runs with both commands");
	fwd_start_a: assert property ($rose(motor_fwd_r) |->
		$past(forward_run_cmd, 2) && !$past(reverse_run_cmd, 2) &&
		$past(main_power_ok, 2) && !$past(trip_active, 2))
		else $error("forward start without ready command");
	rev_start_a: assert property ($rose(motor_rev_r) |->
		$past(reverse_run_cmd, 2) && !$past(forward_run_cmd, 2) &&
		$past(main_power_ok, 2) && !$past(trip_active, 2))
		else $error("reverse start without ready command");
endmodule // dsf_status_flags_checker

bind dsf_status_flags dsf_status_flags_checker #(.NUM_TERM(NUM_TERM)) i_checker (
	.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .prdata_r(prdata_r),
	.pready_r(pready_r), .pslverr_r(pslverr_r), .forward_run_cmd(forward_run_cmd),
	.reverse_run_cmd(reverse_run_cmd), .main_power_ok(main_power_ok),
	.trip_active(trip_active), .motor_fwd_r(motor_fwd_r), .motor_rev_r(motor_rev_r),
	.term_out(term_out), .relay_out(relay_out));

// ---- verif/dsf_core_model.sv ----
// Drive core model: speed ramp giving constant speed and stopping state
`timescale 1ns/1ps

module dsf_core_model #(
	parameter RAMP = 30
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Motor command from the block
	input wire motor_fwd_r,
	input wire motor_rev_r,
	// Run state
	output wire motor_stopping,
	output wire const_speed
);
	localparam [5:0] TOP = RAMP;
	reg [5:0] speed_r;
	wire run = motor_fwd_r | motor_rev_r;

	always @(posedge clk) begin
		if (!rst_n) begin
			speed_r <= 6'h00;
		end else if (run && speed_r != TOP) begin
			speed_r <= speed_r + 6'h01;
		end else if (!run && speed_r != 6'h00) begin
			speed_r <= speed_r - 6'h01;
		end
	end
	assign const_speed = run && (speed_r == TOP);
	assign motor_stopping = !run && (speed_r != 6'h00);
endmodule // dsf_core_model

// ---- verif/testbench.sv ----
// Self-checking testbench for the drive status flag block
`timescale 1ns/1ps
`include "dsf_defs.vh"

module testbench;
	localparam RAMP = 30;
	localparam logic [31:0] SEL = {2'h0, `DSF_FN_FWD, `DSF_FN_READY, `DSF_FN_LOW_CUR,
		`DSF_FN_OVERHEAT, `DSF_FN_START};
	logic [7:0] codes [8] = '{`DSF_TRIP_CT, `DSF_TRIP_CPU, `DSF_TRIP_GND, `DSF_TRIP_FAN,
		`DSF_TRIP_GA, `DSF_TRIP_MAIN, 8'h0c, 8'h0a};
	reg clk = 1'b0;
	reg rst_n = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h0;
	reg forward_run_cmd = 1'b0;
	reg reverse_run_cmd = 1'b0;
	reg main_power_ok = 1'b0;
	reg [7:0] heatsink_temp = 8'h19;
	reg [15:0] output_current = 16'h0000;
	reg [15:0] rated_current = 16'h0064;
	reg trip_active = 1'b0;
	reg trip_hw = 1'b0;
	reg [7:0] trip_code = 8'h00;
	wire [31:0] prdata_r;
	wire pready_r, pslverr_r, motor_fwd_r, motor_rev_r, motor_stopping, const_speed;
	wire [4:0] term_out;
	wire relay_out;
	logic [31:0] rd_v;
	logic er_v;
	int miscompares = 0;
	int compares = 0;

	always #20 clk = ~clk;

	dsf_status_flags i_dut (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r),
		.pslverr_r(pslverr_r), .forward_run_cmd(forward_run_cmd),
		.reverse_run_cmd(reverse_run_cmd), .main_power_ok(main_power_ok),
		.motor_stopping(motor_stopping), .const_speed(const_speed),
		.heatsink_temp(heatsink_temp), .output_current(output_current),
		.rated_current(rated_current), .trip_active(trip_active), .trip_hw(trip_hw),
		.trip_code(trip_code), .motor_fwd_r(motor_fwd_r), .motor_rev_r(motor_rev_r),
		.term_out(term_out), .relay_out(relay_out));

	dsf_core_model #(.RAMP(RAMP)) i_core (
		.clk(clk), .rst_n(rst_n), .motor_fwd_r(motor_fwd_r), .motor_rev_r(motor_rev_r),
		.motor_stopping(motor_stopping), .const_speed(const_speed));

	task complete_run;
		if (miscompares == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task flag(input string name, input logic seen, input logic exp);
		check(name, {31'h0, seen}, {31'h0, exp});
	endtask

	task apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wdata;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready_r !== 1'b1 && n < 50);
		flag("pready", pready_r, 1'b1);
		rd_v = prdata_r;
		er_v = pslverr_r;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [11:0] addr, input logic [31:0] data);
		apb(1'b1, addr, data);
		flag("write error", er_v, 1'b0);
	endtask

	task rd(input logic [11:0] addr, input logic [31:0] exp, input logic err);
		apb(1'b0, addr, 32'h0);
		check("read data", rd_v, exp);
		flag("read error", er_v, err);
	endtask

	task settle;
		repeat (6) @(posedge clk);
	endtask

	task term(input int i, input logic exp);
		flag($sformatf("term %0d", i), term_out[i], exp);
	endtask

	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rd(`DSF_OFS_CTRL, 32'h0, 1'b0);
		rd(`DSF_OFS_THRESH, {`DSF_RST_LEVEL, 8'h00, `DSF_RST_TEMP}, 1'b0);
		wr(`DSF_OFS_THRESH, 32'h00ff_00ff);
		// Stored threshold above 200 must act as 200
		heatsink_temp <= 8'hc9;
		rd(`DSF_OFS_THRESH, 32'h00ff_00ff, 1'b0);
		rd(`DSF_OFS_STATUS, 32'h0000_0002, 1'b0);
		heatsink_temp <= 8'h19;
		wr(`DSF_OFS_TERM_SEL, SEL);
		rd(`DSF_OFS_TERM_SEL, SEL, 1'b0);
		wr(`DSF_OFS_RELAY_SEL, {26'h0, `DSF_FN_REV});
		rd(12'h020, 32'h0, 1'b1);
		wr(`DSF_OFS_THRESH, 32'h0032_0064);
		settle;
		term(3, 1'b0);
		forward_run_cmd <= 1'b1;
		settle;
		term(4, 1'b0);
		main_power_ok <= 1'b1;
		settle;
		term(3, 1'b1);
		term(4, 1'b0);
		forward_run_cmd <= 1'b0;
		settle;
		forward_run_cmd <= 1'b1;
		settle;
		term(4, 1'b1);
		flag("motor fwd", motor_fwd_r, 1'b1);
		term(0, 1'b1);
		flag("relay", relay_out, 1'b0);
		reverse_run_cmd <= 1'b1;
		settle;
		term(4, 1'b0);
		flag("motor fwd", motor_fwd_r, 1'b0);
		flag("motor rev", motor_rev_r, 1'b0);
		flag("relay", relay_out, 1'b0);
		forward_run_cmd <= 1'b0;
		reverse_run_cmd <= 1'b0;
		repeat (RAMP + 6) @(posedge clk);
		term(0, 1'b0);
		output_current <= 16'h0032;
		reverse_run_cmd <= 1'b1;
		settle;
		flag("relay", relay_out, 1'b1);
		flag("motor rev", motor_rev_r, 1'b1);
		term(4, 1'b0);
		term(2, 1'b1);
		wr(`DSF_OFS_CTRL, 32'h0000_0008);
		settle;
		term(2, 1'b0);
		repeat (RAMP) @(posedge clk);
		term(2, 1'b1);
		output_current <= 16'h0033;
		settle;
		term(2, 1'b0);
		// Level above twice rated current acts as twice rated
		wr(`DSF_OFS_THRESH, 32'hffff_0064);
		output_current <= 16'h00c9;
		settle;
		term(2, 1'b0);
		output_current <= 16'h00c8;
		settle;
		term(2, 1'b1);
		reverse_run_cmd <= 1'b0;
		settle;
		flag("relay", relay_out, 1'b0);
		heatsink_temp <= 8'h64;
		settle;
		term(1, 1'b0);
		heatsink_temp <= 8'h65;
		settle;
		term(1, 1'b1);
		// Register source, both directions: start flag without motor
		wr(`DSF_OFS_CTRL, 32'h0000_0007);
		settle;
		term(0, 1'b1);
		term(4, 1'b0);
		wr(`DSF_OFS_CTRL, 32'h0000_0001);
		settle;
		term(0, 1'b0);
		wr(`DSF_OFS_RELAY_SEL, {26'h0, `DSF_FN_MAJOR});
		for (int i = 0; i < 8; i++) begin
			trip_code <= codes[i];
			trip_hw <= (i != 7);
			trip_active <= 1'b1;
			settle;
			flag("major", relay_out, (i < 6));
			trip_active <= 1'b0;
			settle;
		end
		complete_run;
	end

	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		complete_run;
	end
endmodule // testbench
